/* design/rx_agc_and_tx_shaping_control.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_agc_and_tx_shaping_control (
  // Clock and reset
  input  wire logic                             mclk,
  input  wire logic                             rst,
  // AXI4-Lite write address and data
  input  wire logic [rx_agc_pkg::ADDR_W-1:0]    awaddr,
  input  wire logic                             awvalid,
  output logic                                  awready,
  input  wire logic [31:0]                      wdata,
  input  wire logic [3:0]                       wstrb,
  input  wire logic                             wvalid,
  output logic                                  wready,
  // AXI4-Lite write response
  output logic [1:0]                            bresp,
  output logic                                  bvalid,
  input  wire logic                             bready,
  // AXI4-Lite read
  input  wire logic [rx_agc_pkg::ADDR_W-1:0]    araddr,
  input  wire logic                             arvalid,
  output logic                                  arready,
  output logic [31:0]                           rdata,
  output logic [1:0]                            rresp,
  output logic                                  rvalid,
  input  wire logic                             rready,
  // Analog receiver side
  input  wire logic                             carrierTick,
  input  wire logic                             levelAboveRef,
  output logic [rx_agc_pkg::GAIN_W-1:0]         rxDivider,
  output logic [1:0]                            gainReferenceSelect,
  // Transmitter side
  input  wire logic                             singlePumpMode,
  input  wire logic                             overshootActive,
  output logic                                  loadModDriverSelect,
  output logic [1:0]                            cardCarrierAmplitude,
  output logic [4:0]                            residualCarrierLevel,
  output logic                                  shapingBypass,
  output logic [3:0]                            shapingSlewRate,
  output logic [3:0]                            fallTimeConstant,
  output logic [3:0]                            riseTimeConstant
);

  // ************************************************************
  // Helpers
  // ************************************************************

  // Maps a byte address onto one of the registers, word aligned only.
  function automatic rx_agc_pkg::regsel_t decodeAddr(input logic [rx_agc_pkg::ADDR_W-1:0] a);
    rx_agc_pkg::regsel_t s;
    s = rx_agc_pkg::SEL_NONE;
    if (a[1:0] != 2'h0) begin
      s = rx_agc_pkg::SEL_NONE;
    end else if (a[9:2] == rx_agc_pkg::IDX_GAIN_STATUS) begin
      s = rx_agc_pkg::SEL_STATUS;
    end else if (a[9:2] == rx_agc_pkg::IDX_REF_CONFIG) begin
      s = rx_agc_pkg::SEL_CONFIG;
    end else if (a[9:2] == rx_agc_pkg::IDX_STATIC) begin
      s = rx_agc_pkg::SEL_STATIC;
    end else if (a[9:2] == rx_agc_pkg::IDX_TX_CONTROL) begin
      s = rx_agc_pkg::SEL_TX;
    end
    return s;
  endfunction

  // Merges write data into an old word under the byte strobes.
  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // ************************************************************
  // Storage
  // ************************************************************
  logic [rx_agc_pkg::ADDR_W-1:0] awAddr_r;
  logic                          awHeld_r;
  logic [31:0]                   wData_r;
  logic [3:0]                    wStrb_r;
  logic                          wHeld_r;
  logic [rx_agc_pkg::CFG_W-1:0]  cfg_r;
  logic [rx_agc_pkg::STAT_W-1:0] static_r;
  logic [rx_agc_pkg::TX_W-1:0]   tx_r;
  logic [rx_agc_pkg::GAIN_W-1:0] divider_r;
  logic [rx_agc_pkg::GAIN_W-1:0] divider_nxt;
  logic [9:0]                    periodCnt_r;
  logic                          loadPulse_r;
  logic                          writeGo;
  logic                          periodEnd;
  logic [31:0]                   wordNow;
  logic [31:0]                   wordNew;
  rx_agc_pkg::regsel_t           wrSel;

  // Field views of the configuration word.
  logic [9:0]                    timeConst;
  logic                          sourceSel;
  logic                          fixSel;
  logic                          regEnable;
  logic [rx_agc_pkg::GAIN_W-1:0] selectedStatic;

  assign timeConst = cfg_r[rx_agc_pkg::CFG_TC_LSB +: 10];
  assign sourceSel = cfg_r[rx_agc_pkg::CFG_SRC_BIT];
  assign fixSel    = cfg_r[rx_agc_pkg::CFG_FIX_BIT];
  assign regEnable = cfg_r[rx_agc_pkg::CFG_EN_BIT];

  // A write completes once both halves are held and no answer is pending.
  assign writeGo = awHeld_r && wHeld_r && !bvalid;
  assign wrSel   = decodeAddr(awAddr_r);

  // ************************************************************
  // Write channels
  // ************************************************************

  // Address and data are taken in either order and held until used.
  always_ff @(posedge mclk) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      awAddr_r <= '0;
    end else if (awvalid && awready) begin
      awHeld_r <= 1'b1;
      awAddr_r <= awaddr;
    end else if (writeGo) begin
      awHeld_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wHeld_r <= 1'b0;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
    end else if (wvalid && wready) begin
      wHeld_r <= 1'b1;
      wData_r <= wdata;
      wStrb_r <= wstrb;
    end else if (writeGo) begin
      wHeld_r <= 1'b0;
    end
  end

  // Ready is high only while the slot is empty and no response is pending, so a held beat blocks the next.
  always_ff @(posedge mclk) begin
    if (rst) begin
      awready <= 1'b0;
      wready  <= 1'b0;
    end else begin
      awready <= !awHeld_r && !(awvalid && awready) && !bvalid;
      wready  <= !wHeld_r && !(wvalid && wready) && !bvalid;
    end
  end

  // Response, with an error for any address outside the map.
  always_ff @(posedge mclk) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp  <= rx_agc_pkg::RESP_OKAY;
    end else if (writeGo) begin
      bvalid <= 1'b1;
      bresp  <= (wrSel == rx_agc_pkg::SEL_NONE) ? rx_agc_pkg::RESP_SLVERR : rx_agc_pkg::RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Current contents of the written register, for byte merging.
  always_comb begin
    wordNow = 32'h00000000;
    case (wrSel)
      rx_agc_pkg::SEL_CONFIG: wordNow = {16'h0000, cfg_r};
      rx_agc_pkg::SEL_STATIC: wordNow = {12'h000, static_r};
      rx_agc_pkg::SEL_TX:     wordNow = {5'h00, tx_r};
      default:                wordNow = 32'h00000000;
    endcase
  end

  assign wordNew = mergeBytes(wordNow, wData_r, wStrb_r);

  // ************************************************************
  // Registers
  // ************************************************************

  // Configuration word; the load bit is never stored, so it reads zero.
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_r <= rx_agc_pkg::CFG_RESET;
    end else if (writeGo && wrSel == rx_agc_pkg::SEL_CONFIG) begin
      cfg_r                             <= wordNew[rx_agc_pkg::CFG_W-1:0];
      cfg_r[rx_agc_pkg::CFG_LOAD_BIT]   <= 1'b0;
    end
  end

  // One-cycle strobe for a write of one to the load bit in the low byte.
  always_ff @(posedge mclk) begin
    if (rst) begin
      loadPulse_r <= 1'b0;
    end else begin
      loadPulse_r <= writeGo && wrSel == rx_agc_pkg::SEL_CONFIG && wStrb_r[0]
                     && wData_r[rx_agc_pkg::CFG_LOAD_BIT];
    end
  end

  // Static reader and card values.
  always_ff @(posedge mclk) begin
    if (rst) begin
      static_r <= rx_agc_pkg::STAT_RESET;
    end else if (writeGo && wrSel == rx_agc_pkg::SEL_STATIC) begin
      static_r <= wordNew[rx_agc_pkg::STAT_W-1:0];
    end
  end

  // Transmitter control word.
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_r <= rx_agc_pkg::TX_RESET;
    end else if (writeGo && wrSel == rx_agc_pkg::SEL_TX) begin
      tx_r <= wordNew[rx_agc_pkg::TX_W-1:0];
    end
  end

  // ************************************************************
  // Read channel
  // ************************************************************

  // One read at a time; the address is taken only while no data is pending.
  always_ff @(posedge mclk) begin
    if (rst) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= rx_agc_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= rx_agc_pkg::RESP_OKAY;
      case (decodeAddr(araddr))
        rx_agc_pkg::SEL_STATUS: rdata <= {22'h000000, divider_r};
        rx_agc_pkg::SEL_CONFIG: rdata <= {16'h0000, cfg_r};
        rx_agc_pkg::SEL_STATIC: rdata <= {12'h000, static_r};
        rx_agc_pkg::SEL_TX:     rdata <= {5'h00, tx_r};
        default: begin
          rdata <= 32'h00000000;
          rresp <= rx_agc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid) begin
      if (rready) begin
        rvalid <= 1'b0;
      end
    end else begin
      arready <= 1'b1;
    end
  end

  // ************************************************************
  // Gain loop
  // ************************************************************

  assign selectedStatic = sourceSel ? static_r[rx_agc_pkg::STAT_RM_LSB +: 10]
                                    : static_r[rx_agc_pkg::STAT_CM_LSB +: 10];

  assign periodEnd = carrierTick && (periodCnt_r >= timeConst);

  // Carrier cycles counted from zero up to the time constant. Values below
  // the allowed minimum still run, just with a period too short to settle.
  always_ff @(posedge mclk) begin
    if (rst) begin
      periodCnt_r <= 10'h000;
    end else if (!regEnable || periodEnd) begin
      periodCnt_r <= 10'h000;
    end else if (carrierTick) begin
      periodCnt_r <= periodCnt_r + 10'h001;
    end
  end

  // Next divider value: a load wins over regulation, fix mode holds.
  always_comb begin
    divider_nxt = divider_r;
    if (loadPulse_r && (regEnable || !fixSel)) begin
      divider_nxt = selectedStatic;
    end else if (regEnable) begin
      if (periodEnd) begin
        if (levelAboveRef && divider_r != rx_agc_pkg::GAIN_MAX) begin
          divider_nxt = divider_r + 10'h001;
        end else if (!levelAboveRef && divider_r != rx_agc_pkg::GAIN_RESET) begin
          divider_nxt = divider_r - 10'h001;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      divider_r <= rx_agc_pkg::GAIN_RESET;
    end else begin
      divider_r <= divider_nxt;
    end
  end

  // Divider and setpoint to the analog receiver.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rxDivider           <= rx_agc_pkg::GAIN_RESET;
      gainReferenceSelect <= 2'h0;
    end else begin
      rxDivider           <= divider_nxt;
      gainReferenceSelect <= cfg_r[rx_agc_pkg::CFG_REF_LSB +: 2];
    end
  end

  // ************************************************************
  // Transmitter shaping outputs
  // ************************************************************

  // Effective settings after the documented overrides are applied.
  always_ff @(posedge mclk) begin
    if (rst) begin
      loadModDriverSelect  <= 1'b0;
      cardCarrierAmplitude <= 2'h0;
      residualCarrierLevel <= 5'h00;
      shapingBypass        <= 1'b0;
      shapingSlewRate      <= 4'h0;
      fallTimeConstant     <= 4'h0;
      riseTimeConstant     <= 4'h0;
    end else begin
      loadModDriverSelect  <= tx_r[rx_agc_pkg::TX_TYPE_BIT];
      cardCarrierAmplitude <= tx_r[rx_agc_pkg::TX_MAX_BIT] ? rx_agc_pkg::AMP_MAX
                                                           : tx_r[rx_agc_pkg::TX_AMP_LSB +: 2];
      residualCarrierLevel <= overshootActive ? tx_r[rx_agc_pkg::TX_OVR_LSB +: 5]
                                              : tx_r[rx_agc_pkg::TX_RES_LSB +: 5];
      shapingBypass        <= tx_r[rx_agc_pkg::TX_BYP_BIT];
      shapingSlewRate      <= tx_r[rx_agc_pkg::TX_SLEW_LSB +: 4];
      fallTimeConstant     <= singlePumpMode ? tx_r[rx_agc_pkg::TX_FALL_LSB +: 4] : 4'h0;
      riseTimeConstant     <= (singlePumpMode && !tx_r[rx_agc_pkg::TX_BYP_BIT])
                              ? tx_r[rx_agc_pkg::TX_RISE_LSB +: 4] : 4'h0;
    end
  end

endmodule
`default_nettype wire

/* design/rx_agc_pkg.sv */
// Behaviour
// - Two-bit field picks gain setpoint, 11b reserved
// - Update period is time constant plus one
// - Source bit picks card or reader value
// - Load bit copies static value, self-clears
// - Fix bit 0: divider takes static value
// - Fix bit 1: divider keeps frozen setting
// - Fix bit change alone never loads divider
// - Enable bit switches fixed versus regulated divider
// - Static register holds reader and card values
// - Driver-type bit selects both or single driver
// - Force bit overrides card carrier amplitude to max
// - Residual code 0 full, 1F zero carrier
// - Overshoot residual applies only during prevention pattern
// - Bypass bit disables rising-edge shaping constant
// - Slew field sets regulator slew, both edges
// - Edge time constants apply only in single-pump mode
// - Readable field reports current gain value
`default_nettype none
package rx_agc_pkg;

  // ************************************************************
  // Register map (indices; byte address is four times the index)
  // ************************************************************
  localparam int unsigned ADDR_W          = 10;
  localparam logic [7:0]  IDX_GAIN_STATUS = 8'h1d;
  localparam logic [7:0]  IDX_REF_CONFIG  = 8'h1e;
  localparam logic [7:0]  IDX_STATIC      = 8'h1f;
  localparam logic [7:0]  IDX_TX_CONTROL  = 8'h20;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int unsigned CFG_W        = 16;
  localparam int unsigned CFG_REF_LSB  = 14;
  localparam int unsigned CFG_TC_LSB   = 4;
  localparam int unsigned CFG_SRC_BIT  = 3;
  localparam int unsigned CFG_LOAD_BIT = 2;
  localparam int unsigned CFG_FIX_BIT  = 1;
  localparam int unsigned CFG_EN_BIT   = 0;
  localparam int unsigned GAIN_W       = 10;
  localparam int unsigned STAT_W       = 20;
  localparam int unsigned STAT_RM_LSB  = 10;
  localparam int unsigned STAT_CM_LSB  = 0;
  localparam int unsigned TX_W         = 27;
  localparam int unsigned TX_TYPE_BIT  = 26;
  localparam int unsigned TX_AMP_LSB   = 24;
  localparam int unsigned TX_OVR_LSB   = 19;
  localparam int unsigned TX_MAX_BIT   = 18;
  localparam int unsigned TX_RES_LSB   = 13;
  localparam int unsigned TX_BYP_BIT   = 12;
  localparam int unsigned TX_SLEW_LSB  = 8;
  localparam int unsigned TX_FALL_LSB  = 4;
  localparam int unsigned TX_RISE_LSB  = 0;
  localparam logic [CFG_W-1:0]  CFG_RESET  = 16'h0000;
  localparam logic [STAT_W-1:0] STAT_RESET = 20'h00000;
  localparam logic [TX_W-1:0]   TX_RESET   = 27'h0000000;
  localparam logic [GAIN_W-1:0] GAIN_RESET = 10'h000;
  localparam logic [GAIN_W-1:0] GAIN_MAX   = 10'h3ff;
  localparam logic [1:0]        AMP_MAX    = 2'h3;

  // ************************************************************
  // Bus answers and decode
  // ************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {SEL_NONE, SEL_STATUS, SEL_CONFIG, SEL_STATIC, SEL_TX} regsel_t;

endpackage
`default_nettype wire

/* verification/rx_agc_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bus handshake, gain loop and transmit shaping checks
// ****************************************
module rx_agc_checker (
  // Clock and reset
  input wire logic                         mclk,
  input wire logic                         rst,
  // Bus handshakes
  input wire logic                         awvalid,
  input wire logic                         awready,
  input wire logic                         wvalid,
  input wire logic                         wready,
  input wire logic [1:0]                   bresp,
  input wire logic                         bvalid,
  input wire logic                         bready,
  input wire logic                         arvalid,
  input wire logic                         arready,
  input wire logic [31:0]                  rdata,
  input wire logic                         rvalid,
  input wire logic                         rready,
  // Gain and transmit side
  input wire logic                         carrierTick,
  input wire logic [rx_agc_pkg::GAIN_W-1:0] rxDivider,
  input wire logic                         singlePumpMode,
  input wire logic                         shapingBypass,
  input wire logic [3:0]                   fallTimeConstant,
  input wire logic [3:0]                   riseTimeConstant
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // A write is checked only when address and data meet at one edge.
  sequence wrTaken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence wrAnswer;
    !bvalid ##1 bvalid;
  endsequence

  // Reset must clear awready, arready, bvalid and the divider, so it is never disabled here.
  reset_clears_a: assert property (disable iff (1'b0) rst |=> !awready && !arready && !bvalid && rxDivider == '0)
    else $error("outputs not cleared by reset");
  write_answer_a: assert property (wrTaken |=> wrAnswer)
    else $error("write answer late or early");
  read_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer missing");
  resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  read_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  // The divider moves only after a load write or a carrier tick.
  div_cause_a: assert property ($changed(rxDivider) |-> $past(carrierTick) || $past(bvalid))
    else $error("divider moved without cause");
  div_step_a: assert property ($changed(rxDivider) && !$past(bvalid) |->
    (rxDivider == $past(rxDivider) + 10'h001) || ($past(rxDivider) == rxDivider + 10'h001))
    else $error("regulation step not one");
  pump_off_a: assert property (!singlePumpMode |=> fallTimeConstant == 4'h0 && riseTimeConstant == 4'h0)
    else $error("edge constants active without single pump");
  bypass_rise_a: assert property (shapingBypass |-> riseTimeConstant == 4'h0)
    else $error("rise constant active under bypass");
endmodule

bind rx_agc_and_tx_shaping_control rx_agc_checker u_rx_agc_checker (
  .mclk(mclk), .rst(rst), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rvalid(rvalid), .rready(rready), .carrierTick(carrierTick), .rxDivider(rxDivider),
  .singlePumpMode(singlePumpMode), .shapingBypass(shapingBypass),
  .fallTimeConstant(fallTimeConstant), .riseTimeConstant(riseTimeConstant)
);
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic        mclk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, carrierTick = 1'b0, levelAboveRef = 1'b0;
  logic        singlePumpMode = 1'b0, overshootActive = 1'b0;
  logic [9:0]  awaddr = '0, araddr = '0, rxDivider, expDiv;
  logic [31:0] wdata = '0, rdata, seed = 32'd32458, sv, txv, r;
  logic [3:0]  wstrb = '0, shapingSlewRate, fallTimeConstant, riseTimeConstant;
  logic        awready, wready, bvalid, arready, rvalid, loadModDriverSelect, shapingBypass, lvl;
  logic [1:0]  bresp, rresp, gainReferenceSelect, cardCarrierAmplitude, spov;
  logic [4:0]  residualCarrierLevel;
  int          mismatches = 0, testsRun = 0;

  rx_agc_and_tx_shaping_control u_rx_agc_and_tx_shaping_control (
    .mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .carrierTick(carrierTick), .levelAboveRef(levelAboveRef),
    .rxDivider(rxDivider), .gainReferenceSelect(gainReferenceSelect), .singlePumpMode(singlePumpMode),
    .overshootActive(overshootActive), .loadModDriverSelect(loadModDriverSelect),
    .cardCarrierAmplitude(cardCarrierAmplitude), .residualCarrierLevel(residualCarrierLevel),
    .shapingBypass(shapingBypass), .shapingSlewRate(shapingSlewRate),
    .fallTimeConstant(fallTimeConstant), .riseTimeConstant(riseTimeConstant));

  // Free-running 25 MHz clock.
  always #20 mclk = ~mclk;

  // Repeatable xorshift source.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Transmit outputs packed as type, amplitude, residual, bypass, slew, fall, rise.
  function automatic logic [20:0] txExp(input logic [31:0] t, input logic sp, input logic ov);
    return {t[26], t[18] ? 2'h3 : t[25:24], ov ? t[23:19] : t[17:13], t[12], t[11:8],
            sp ? t[7:4] : 4'h0, (sp && !t[12]) ? t[3:0] : 4'h0};
  endfunction
  // One regulation step saturates at both ends of the range.
  function automatic logic [9:0] stepExp(input logic [9:0] d, input logic up);
    if (up) return (d == 10'h3ff) ? d : d + 10'h001;
    return (d == 10'h000) ? d : d - 10'h001;
  endfunction

  // Verdict and comparison helpers.
  task automatic conclude();
    $display("Checks run %0d, mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask
  task automatic giveUp(input int n);
    if (n >= 40) begin
      $display("Error handshake expected answer seen none");
      mismatches++;
      conclude();
    end
  endtask

  // Bus master: every channel holds its payload until its own ready is sampled.
  task automatic axiWrite(input logic [7:0] idx, input logic [31:0] d,
                          input logic [1:0] er = rx_agc_pkg::RESP_OKAY);
    int n;
    n = 0;
    awaddr <= {idx, 2'b00};
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid && bready) && n < 40);
    bready <= 1'b0;
    giveUp(n);
    check("bresp", 32'(er), 32'(bresp));
    repeat (2) @(posedge mclk);
  endtask
  task automatic axiRead(input logic [7:0] idx, input logic [31:0] ed,
                         input logic [1:0] er = rx_agc_pkg::RESP_OKAY);
    int n;
    n = 0;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready) && n < 40);
    rready <= 1'b0;
    giveUp(n);
    check("rdata", ed, rdata);
    check("rresp", 32'(er), 32'(rresp));
  endtask
  task automatic cfgWrite(input logic [31:0] d);
    axiWrite(rx_agc_pkg::IDX_REF_CONFIG, d);
  endtask
  task automatic ticks(input int k);
    repeat (k) begin
      carrierTick <= 1'b1;
      @(posedge mclk);
      carrierTick <= 1'b0;
      repeat (2) @(posedge mclk);
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    axiRead(rx_agc_pkg::IDX_GAIN_STATUS, 32'h0);
    axiRead(rx_agc_pkg::IDX_REF_CONFIG, 32'h0);
    axiRead(rx_agc_pkg::IDX_STATIC, 32'h0);
    axiRead(rx_agc_pkg::IDX_TX_CONTROL, 32'h0);
    axiRead(8'h00, 32'h0, rx_agc_pkg::RESP_SLVERR);
    axiWrite(8'h00, rnd(), rx_agc_pkg::RESP_SLVERR);
    // Card value loaded by the strobe, which then reads back clear.
    sv = rnd();
    axiWrite(rx_agc_pkg::IDX_STATIC, sv);
    axiRead(rx_agc_pkg::IDX_STATIC, {12'h0, sv[19:0]});
    cfgWrite(32'h0000_0044);
    check("rxDivider", 32'(sv[9:0]), 32'(rxDivider));
    axiRead(rx_agc_pkg::IDX_REF_CONFIG, 32'h0000_0040);
    // Reader value at the top of the range, then regulation with period five ticks.
    sv = {12'h0, 10'h3ff, sv[9:0]};
    axiWrite(rx_agc_pkg::IDX_STATIC, sv);
    cfgWrite(32'h0000_004d);
    expDiv = 10'h3ff;
    check("rxDivider", 32'(expDiv), 32'(rxDivider));
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      lvl = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : r[0];
      levelAboveRef <= lvl;
      ticks(4);
      check("rxDivider", 32'(expDiv), 32'(rxDivider));
      ticks(1);
      expDiv = stepExp(expDiv, lvl);
      check("rxDivider", 32'(expDiv), 32'(rxDivider));
    end
    // Frozen divider ignores loads and ticks until the fix bit is cleared.
    cfgWrite(32'h0000_0042);
    cfgWrite(32'h0000_004e);
    ticks(6);
    check("rxDivider", 32'(expDiv), 32'(rxDivider));
    axiRead(rx_agc_pkg::IDX_GAIN_STATUS, 32'(expDiv));
    cfgWrite(32'h0000_0040);
    check("rxDivider", 32'(expDiv), 32'(rxDivider));
    cfgWrite(32'h0000_0044);
    check("rxDivider", 32'(sv[9:0]), 32'(rxDivider));
    for (int c = 0; c < 4; c++) begin
      cfgWrite((32'(c) << 14) | 32'h0000_0040);
      check("gainReferenceSelect", 32'(c), 32'(gainReferenceSelect));
    end
    // Transmit fields with random pump and overshoot inputs.
    for (int i = 0; i < 12; i++) begin
      txv = (i == 0) ? 32'hffff_ffff : rnd();
      r = rnd();
      spov = (i == 0) ? 2'h3 : r[1:0];
      singlePumpMode <= spov[0];
      overshootActive <= spov[1];
      axiWrite(rx_agc_pkg::IDX_TX_CONTROL, txv);
      check("txOutputs", 32'(txExp(txv, spov[0], spov[1])), 32'({loadModDriverSelect, cardCarrierAmplitude,
            residualCarrierLevel, shapingBypass, shapingSlewRate, fallTimeConstant, riseTimeConstant}));
      axiRead(rx_agc_pkg::IDX_TX_CONTROL, {5'h0, txv[26:0]});
    end
    conclude();
  end
endmodule
`default_nettype wire
